// ### plss_top.sv
`timescale 1ns/1ps
`default_nettype none

module plss_top #(
    parameter int TICK_CYCLES = plss_pkg::TIME_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Settings.
    input wire plss_pkg::plss_cfg_s cfg,
    // Loop controller and feedback.
    input wire plss_pkg::plss_loop_s loop,
    // Speed commands, target, scaled feedback, stop control, alarms and sleep status.
    output plss_pkg::plss_out_s result
);

    typedef struct packed {
        logic [plss_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
        plss_pkg::plss_sleep_e mode;
        plss_pkg::plss_out_s out;
    } plss_state_s;

    // Scales a frequency by a ratio; the result saturates at the full-scale code.
    function automatic logic [plss_pkg::FREQ_W-1:0] scale_freq(
        input logic [plss_pkg::FREQ_W-1:0] freq,
        input logic [9:0] num,
        input int den
    );
        logic [25:0] prod;
        prod = (26'(freq) * 26'(num)) / 26'(den);
        if (prod > 26'(plss_pkg::FREQ_MAX)) begin
            return plss_pkg::FREQ_MAX;
        end
        return prod[plss_pkg::FREQ_W-1:0];
    endfunction

    function automatic logic [plss_pkg::FREQ_W-1:0] abs_diff(
        input logic [plss_pkg::FREQ_W-1:0] a,
        input logic [plss_pkg::FREQ_W-1:0] b
    );
        return (a > b) ? (a - b) : (b - a);
    endfunction

    logic rst_meta;
    logic rst_n;
    plss_state_s state;
    plss_state_s next_state;

    logic fault_hold;
    logic fault_expired;
    logic offset_hold;
    logic offset_expired;
    logic sleep_hold;
    logic sleep_expired;
    logic wake_hold;
    logic wake_expired;

    logic [plss_pkg::FREQ_W-1:0] limit_freq;
    logic [plss_pkg::FREQ_W-1:0] clamped;
    logic [plss_pkg::FREQ_W-1:0] floor_freq;
    logic [plss_pkg::FREQ_W-1:0] target;
    logic [plss_pkg::FREQ_W-1:0] scaled_fb;
    logic [plss_pkg::FREQ_W-1:0] offset_limit;
    logic [plss_pkg::FREQ_W-1:0] shaped;
    logic sleep_ok;

    // The reset is released through two flops so that all logic leaves reset on one edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        limit_freq = scale_freq(cfg.max_output_freq, 10'(cfg.loop_output_limit_pct), plss_pkg::PCT_DIV);
        clamped = (loop.loop_freq > limit_freq) ? limit_freq : loop.loop_freq;
        // A single scaled value feeds both the offset check and the scaled feedback output.
        scaled_fb = scale_freq(loop.raw_feedback, 10'(cfg.feedback_gain), plss_pkg::GAIN_DIV);
        offset_limit = scale_freq(cfg.max_output_freq, 10'(cfg.offset_level), plss_pkg::LVL_DIV);
        if (cfg.min_freq_source == plss_pkg::PLSS_MIN_FROM_SETTING) begin
            floor_freq = cfg.min_output_freq;
        end else begin
            floor_freq = loop.loop_lower_bound;
        end
        case (cfg.target_source_select)
            plss_pkg::PLSS_TGT_KEYPAD: target = loop.keypad_target;
            plss_pkg::PLSS_TGT_ANALOG1: target = loop.analog1_target;
            plss_pkg::PLSS_TGT_ANALOG2: target = loop.analog2_target;
            plss_pkg::PLSS_TGT_STORED: target = cfg.stored_target_freq;
            default: target = plss_pkg::FREQ_ZERO;
        endcase
    end

    // Timer conditions.
    assign fault_hold = loop.loop_active && (cfg.feedback_fault_time != plss_pkg::TIME_ZERO)
        && (loop.analog_fb_abnormal || loop.encoder_pulse_feedback_abnormal);
    assign offset_hold = loop.loop_active && (abs_diff(target, scaled_fb) > offset_limit);
    assign sleep_hold = cfg.sleep_enable && (state.mode == plss_pkg::PLSS_RUN)
        && (loop.output_freq <= cfg.sleep_freq);
    assign wake_hold = (state.mode == plss_pkg::PLSS_SLEEP) && (clamped > cfg.wake_freq);
    assign sleep_ok = sleep_expired || (state.mode == plss_pkg::PLSS_SLEEP);

    plss_timer u_fault_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(state.tick),
        .hold(fault_hold),
        .limit(cfg.feedback_fault_time),
        .expired(fault_expired)
    );

    plss_timer u_offset_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(state.tick),
        .hold(offset_hold),
        .limit(cfg.offset_time),
        .expired(offset_expired)
    );

    plss_timer u_sleep_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(state.tick),
        .hold(sleep_hold),
        .limit(cfg.sleep_wake_time),
        .expired(sleep_expired)
    );

    plss_timer u_wake_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(state.tick),
        .hold(wake_hold),
        .limit(cfg.sleep_wake_time),
        .expired(wake_expired)
    );

    // Shaping of the command near the floor.
    always_comb begin
        if (clamped < cfg.min_output_freq) begin
            if (!cfg.sleep_enable || sleep_ok) begin
                shaped = plss_pkg::FREQ_ZERO;
            end else begin
                shaped = floor_freq;
            end
        end else if (clamped < floor_freq) begin
            if (cfg.sleep_enable && sleep_ok) begin
                shaped = plss_pkg::FREQ_ZERO;
            end else begin
                shaped = floor_freq;
            end
        end else begin
            shaped = clamped;
        end
    end

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        next_state.out.wake_start = 1'b0;
        if (state.tick_cnt == plss_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            next_state.tick_cnt = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.tick_cnt = state.tick_cnt + 24'h000001;
        end

        case (state.mode)
            plss_pkg::PLSS_RUN: begin
                if (sleep_expired) begin
                    next_state.mode = plss_pkg::PLSS_SLEEP;
                end
            end
            plss_pkg::PLSS_SLEEP: begin
                if (wake_expired || !cfg.sleep_enable) begin
                    next_state.mode = plss_pkg::PLSS_RUN;
                    next_state.out.wake_start = 1'b1;
                end
            end
            default: next_state.mode = plss_pkg::PLSS_RUN;
        endcase

        // The loop command keeps tracking while asleep so the wake test sees live data.
        next_state.out.loop_cmd = clamped;
        if (next_state.mode == plss_pkg::PLSS_SLEEP) begin
            next_state.out.drive_cmd = plss_pkg::FREQ_ZERO;
        end else if (next_state.out.wake_start) begin
            next_state.out.drive_cmd = cfg.min_output_freq;
        end else begin
            next_state.out.drive_cmd = shaped;
        end
        next_state.out.sleeping = (next_state.mode == plss_pkg::PLSS_SLEEP);
        next_state.out.target = target;
        next_state.out.scaled_feedback = scaled_fb;
        next_state.out.feedback_warning = fault_expired;
        next_state.out.stop_ramp = fault_expired
            && (cfg.feedback_fault_action == plss_pkg::PLSS_ACT_RAMP);
        next_state.out.stop_coast = fault_expired
            && (cfg.feedback_fault_action == plss_pkg::PLSS_ACT_COAST);
        next_state.out.offset_alarm = offset_expired;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign result = state.out;

endmodule

`default_nettype wire

// ### plss_pkg.sv
`default_nettype none

package plss_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIME_STEP_MS = 100;
    localparam int TIME_STEP_CYCLES = (TIME_STEP_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TICK_W = 24;

    // Widths of settings and data.
    localparam int FREQ_W = 16;
    localparam int TIME_W = 16;
    localparam int PCT_W = 7;
    localparam int GAIN_W = 7;
    localparam int LVL_W = 9;

    // Scale divisors: percent, gain in tenths, level in tenths of a percent.
    localparam int PCT_DIV = 100;
    localparam int GAIN_DIV = 10;
    localparam int LVL_DIV = 1000;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hFFFF;
    localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;

    // Reset values of settings for software to load.
    localparam logic [PCT_W-1:0] LIMIT_PCT_RESET = 7'h64;
    localparam logic [TIME_W-1:0] FAULT_TIME_RESET = 16'h0258;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 7'h0A;
    localparam logic [LVL_W-1:0] OFFSET_LEVEL_RESET = 9'h064;
    localparam logic [TIME_W-1:0] OFFSET_TIME_RESET = 16'h0032;

    typedef enum logic [1:0] {
        PLSS_ACT_RAMP = 2'h0,
        PLSS_ACT_COAST = 2'h1,
        PLSS_ACT_KEEP = 2'h2
    } plss_action_e;

    typedef enum logic [2:0] {
        PLSS_TGT_OFF = 3'h0,
        PLSS_TGT_KEYPAD = 3'h1,
        PLSS_TGT_ANALOG1 = 3'h2,
        PLSS_TGT_ANALOG2 = 3'h3,
        PLSS_TGT_STORED = 3'h4
    } plss_tgt_e;

    localparam logic PLSS_MIN_FROM_LOOP = 1'b0;
    localparam logic PLSS_MIN_FROM_SETTING = 1'b1;

    typedef enum logic {
        PLSS_RUN = 1'b0,
        PLSS_SLEEP = 1'b1
    } plss_sleep_e;

    typedef struct packed {
        logic [PCT_W-1:0] loop_output_limit_pct;
        logic [TIME_W-1:0] feedback_fault_time;
        plss_action_e feedback_fault_action;
        logic [GAIN_W-1:0] feedback_gain;
        logic [FREQ_W-1:0] stored_target_freq;
        logic [LVL_W-1:0] offset_level;
        logic [TIME_W-1:0] offset_time;
        logic [TIME_W-1:0] sleep_wake_time;
        logic [FREQ_W-1:0] sleep_freq;
        logic [FREQ_W-1:0] wake_freq;
        logic min_freq_source;
        plss_tgt_e target_source_select;
        logic [FREQ_W-1:0] min_output_freq;
        logic [FREQ_W-1:0] max_output_freq;
        logic sleep_enable;
    } plss_cfg_s;

    typedef struct packed {
        logic [FREQ_W-1:0] keypad_target;
        logic [FREQ_W-1:0] analog1_target;
        logic [FREQ_W-1:0] analog2_target;
        logic [FREQ_W-1:0] raw_feedback;
        logic [FREQ_W-1:0] loop_freq;
        logic [FREQ_W-1:0] loop_lower_bound;
        logic [FREQ_W-1:0] output_freq;
        logic analog_fb_abnormal;
        logic encoder_pulse_feedback_abnormal;
        logic loop_active;
    } plss_loop_s;

    typedef struct packed {
        logic [FREQ_W-1:0] loop_cmd;
        logic [FREQ_W-1:0] drive_cmd;
        logic [FREQ_W-1:0] target;
        logic [FREQ_W-1:0] scaled_feedback;
        logic feedback_warning;
        logic stop_ramp;
        logic stop_coast;
        logic offset_alarm;
        logic sleeping;
        logic wake_start;
    } plss_out_s;

endpackage

`default_nettype wire

// ### plss_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts time steps while a condition holds; drops to zero when it fails.
module plss_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Time base and condition.
    input wire logic tick,
    input wire logic hold,
    input wire logic [plss_pkg::TIME_W-1:0] limit,
    // Result.
    output logic expired
);

    typedef struct packed {
        logic [plss_pkg::TIME_W-1:0] count;
    } plss_timer_s;

    plss_timer_s state;
    plss_timer_s next_state;

    always_comb begin
        next_state = state;
        if (!hold) begin
            next_state.count = plss_pkg::TIME_ZERO;
        end else if (tick && state.count < limit) begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = hold && (state.count >= limit);

endmodule

`default_nettype wire

// ### plss_chk.sv
`timescale 1ns/1ps
`default_nettype none

module plss_chk #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Settings and loop side.
    input wire plss_pkg::plss_cfg_s cfg,
    input wire plss_pkg::plss_loop_s loop,
    // Outputs.
    input wire plss_pkg::plss_out_s result
);
    // Outputs are zero until the internal reset copy is released, so value checks wait a few cycles.
    logic [2:0] up;
    logic [23:0] lim;
    logic [15:0] e_cmd;
    wire ready = up == 3'h7;
    wire abn = loop.analog_fb_abnormal | loop.encoder_pulse_feedback_abnormal;
    always_comb begin
        lim = 24'(cfg.max_output_freq) * 24'(cfg.loop_output_limit_pct) / 24'h64;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up <= 3'h0;
            e_cmd <= 16'h0000;
        end else begin
            up <= up + 3'(up != 3'h7);
            e_cmd <= (24'(loop.loop_freq) < lim) ? loop.loop_freq : lim[15:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_cmd_clamp: assert property (ready |-> result.loop_cmd == e_cmd)
        else $error("loop command off clamp");
    chk_warn_delay: assert property (ready && $rose(result.feedback_warning) |-> $past(abn) && $past(abn, 2))
        else $error("warning without held fault");
    chk_detect_off: assert property ((ready && cfg.feedback_fault_time == 16'h0000)[*3] |-> !result.feedback_warning)
        else $error("warning with detection off");
    chk_ramp_stop: assert property (ready && $stable(cfg.feedback_fault_action) |-> result.stop_ramp ==
        (result.feedback_warning && cfg.feedback_fault_action == plss_pkg::PLSS_ACT_RAMP))
        else $error("ramp stop wrong");
    chk_coast_stop: assert property (ready && $stable(cfg.feedback_fault_action) |-> result.stop_coast ==
        (result.feedback_warning && cfg.feedback_fault_action == plss_pkg::PLSS_ACT_COAST))
        else $error("coast stop wrong");
    chk_sleep_zero: assert property (result.sleeping |-> result.drive_cmd == 16'h0000)
        else $error("command while asleep");
    chk_sleep_cause: assert property (ready && $rose(result.sleeping) |-> $past(loop.output_freq <= cfg.sleep_freq))
        else $error("sleep without low output");
    chk_wake_floor: assert property (result.wake_start |-> !result.sleeping && result.drive_cmd == $past(cfg.min_output_freq))
        else $error("wake not from minimum");
    chk_wake_pulse: assert property (result.wake_start |=> !result.wake_start)
        else $error("wake pulse too long");
    cov_sleep: cover property ($rose(result.sleeping));
    cov_wake: cover property (result.wake_start);
    cov_coast: cover property (result.stop_coast);
endmodule

bind plss_top plss_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .arst_n(arst_n), .cfg(cfg), .loop(loop), .result(result));

`default_nettype wire

// ### plss_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module plss_top_tb;
    typedef struct packed {
        logic [6:0] pct;
        logic [15:0] maxf, lf;
        logic [2:0] sel;
        logic [6:0] gain;
        logic [15:0] raw, ecmd, etgt, efb;
    } plss_row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    plss_pkg::plss_cfg_s cfg = '0;
    plss_pkg::plss_loop_s loop = '0;
    plss_pkg::plss_out_s result;
    int fails = 0;
    int checks = 0;
    // Worked by hand: clamp = max * pct / 100, feedback = raw * gain / 10 saturated.
    plss_row_s rows [6] = '{
        '{7'h64, 16'h1000, 16'h0800, 3'h0, 7'h0A, 16'h0123, 16'h0800, 16'h0000, 16'h0123},
        '{7'h32, 16'h1000, 16'h0900, 3'h1, 7'h00, 16'h0123, 16'h0800, 16'h1111, 16'h0000},
        '{7'h6E, 16'h1000, 16'hFFFF, 3'h2, 7'h64, 16'h1000, 16'h1199, 16'h2222, 16'hA000},
        '{7'h00, 16'h1000, 16'h0005, 3'h3, 7'h64, 16'h2000, 16'h0000, 16'h3333, 16'hFFFF},
        '{7'h64, 16'hFFFF, 16'h1234, 3'h4, 7'h0F, 16'h0064, 16'h1234, 16'h4444, 16'h0096},
        '{7'h64, 16'h1000, 16'h1000, 3'h5, 7'h07, 16'h000F, 16'h1000, 16'h0000, 16'h000A}};

    always #5 clk = ~clk;

    plss_top #(.TICK_CYCLES(4)) uut (.clk(clk), .arst_n(arst_n), .cfg(cfg), .loop(loop), .result(result));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return result.feedback_warning;
            1: return result.offset_alarm;
            2: return result.sleeping;
            default: return result.wake_start;
        endcase
    endfunction

    // Bounded wait; running out of cycles shows up as a mismatch.
    task automatic wait_hi(input int w);
        for (int i = 0; i < 200 && pick(w) !== 1'b1; i++) step(1);
        chk("flag", 16'(pick(w)), 16'h0001);
        if (pick(w) !== 1'b1) begin
            finish_test();
        end
    endtask

    task automatic shape(input logic en, input logic src, input logic [15:0] lf, input logic [15:0] exp);
        @(posedge clk);
        cfg.sleep_enable <= en;
        cfg.min_freq_source <= src;
        loop.loop_freq <= lf;
        step(3);
        chk("drive_cmd", result.drive_cmd, exp);
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        step(10);
        chk("reset", 16'(|result), 16'h0000);
        @(posedge clk);
        arst_n <= 1'b1;
        loop.keypad_target <= 16'h1111;
        loop.analog1_target <= 16'h2222;
        loop.analog2_target <= 16'h3333;
        cfg.stored_target_freq <= 16'h4444;
        step(5);
        foreach (rows[i]) begin
            @(posedge clk);
            cfg.loop_output_limit_pct <= rows[i].pct;
            cfg.max_output_freq <= rows[i].maxf;
            loop.loop_freq <= rows[i].lf;
            cfg.target_source_select <= plss_pkg::plss_tgt_e'(rows[i].sel);
            cfg.feedback_gain <= rows[i].gain;
            loop.raw_feedback <= rows[i].raw;
            step(2);
            chk("loop_cmd", result.loop_cmd, rows[i].ecmd);
            chk("target", result.target, rows[i].etgt);
            chk("feedback", result.scaled_feedback, rows[i].efb);
        end
        @(posedge clk);
        cfg.target_source_select <= plss_pkg::PLSS_TGT_OFF;
        loop.raw_feedback <= 16'h0000;
        cfg.feedback_fault_time <= 16'h0002;
        loop.loop_active <= 1'b1;
        // Action code 3 is not documented and must behave like keep running.
        for (int a = 0; a < 4; a++) begin
            @(posedge clk);
            cfg.feedback_fault_action <= plss_pkg::plss_action_e'(a);
            loop.encoder_pulse_feedback_abnormal <= 1'b1;
            step(3);
            chk("early", 16'(result.feedback_warning), 16'h0000);
            wait_hi(0);
            chk("ramp", 16'(result.stop_ramp), 16'(a == 0));
            chk("coast", 16'(result.stop_coast), 16'(a == 1));
            @(posedge clk);
            loop.encoder_pulse_feedback_abnormal <= 1'b0;
            step(3);
            chk("cleared", 16'(result.feedback_warning), 16'h0000);
        end
        @(posedge clk);
        cfg.feedback_fault_time <= 16'h0000;
        loop.analog_fb_abnormal <= 1'b1;
        step(30);
        chk("off", 16'(result.feedback_warning), 16'h0000);
        @(posedge clk);
        loop.analog_fb_abnormal <= 1'b0;
        cfg.offset_level <= 9'h064;
        cfg.offset_time <= 16'h0001;
        cfg.target_source_select <= plss_pkg::PLSS_TGT_KEYPAD;
        cfg.feedback_gain <= 7'h0A;
        loop.raw_feedback <= 16'h1111;
        step(20);
        chk("offset", 16'(result.offset_alarm), 16'h0000);
        @(posedge clk);
        loop.raw_feedback <= 16'h0000;
        wait_hi(1);
        @(posedge clk);
        loop.loop_active <= 1'b0;
        cfg.sleep_wake_time <= 16'h0002;
        cfg.sleep_freq <= 16'h0100;
        cfg.wake_freq <= 16'h0200;
        cfg.min_output_freq <= 16'h0050;
        loop.loop_lower_bound <= 16'h00C0;
        loop.output_freq <= 16'h0300;
        shape(1'b1, 1'b0, 16'h0080, 16'h00C0);
        shape(1'b1, 1'b0, 16'h0020, 16'h00C0);
        @(posedge clk);
        loop.output_freq <= 16'h0080;
        wait_hi(2);
        chk("asleep", result.loop_cmd, 16'h0020);
        @(posedge clk);
        loop.loop_freq <= 16'h0300;
        loop.output_freq <= 16'h0300;
        step(2);
        chk("waking", 16'(result.sleeping), 16'h0001);
        chk("tracking", result.loop_cmd, 16'h0300);
        wait_hi(3);
        chk("wake", result.drive_cmd, 16'h0050);
        shape(1'b0, 1'b0, 16'h0020, 16'h0000);
        shape(1'b0, 1'b0, 16'h0080, 16'h00C0);
        shape(1'b0, 1'b1, 16'h0080, 16'h0080);
        // A reset in mid-run clears the outputs at once and holds them until the internal copy is released.
        @(posedge clk);
        arst_n <= 1'b0;
        step(1);
        chk("midreset", 16'(|result), 16'h0000);
        @(posedge clk);
        arst_n <= 1'b1;
        step(2);
        chk("held", 16'(|result), 16'h0000);
        step(1);
        chk("restart", result.loop_cmd, 16'h0080);
        finish_test();
    end

    initial begin
        #500000;
        fails++;
        finish_test();
    end
endmodule

`default_nettype wire
